// ### verilog/switchgear_wear_monitor.sv
// Wear statistics for one switchgear instance: operation count, interrupted
// current sums, hourly sum, open capacity from a wear curve and travel timing.
// Assumes commands, currents and settings come from logic on clk_sys; the two
// position contacts are raw pins. Curve points must rise in current.
// Summary of operation
// - Count every switching operation and expose the running count.
// - Raise the operation alarm when the count exceeds the set limit.
// - Add each phase's interrupted current to its own sum on every opening.
// - Raise a summary and per-phase alarm when a sum exceeds its threshold.
// - Keep open capacity in percent; full scale means maintenance is due.
// - Sum interrupted current per hour; alarm when above the hourly limit.
// - Time opening and closing travel; slow alarm when a limit is exceeded.
// - Accept a wear curve of up to ten current and operation points.
// - The last point in use always allows zero operations.
// - Between two points, interpolate the allowed operations linearly.
// - Above the last point's current, allowed operations are zero.
module switchgear_wear_monitor
  import wear_pkg::*;
#(
  parameter int unsigned MS_CYCLES  = MS_CYC,
  parameter int unsigned HOUR_TICKS = HOUR_MS
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic                  open_cmd,
  input  wire logic                  close_cmd,
  input  wire logic                  pos_open_pin,
  input  wire logic                  pos_closed_pin,
  input  wire logic                  stat_clear,
  input  wire wear_pkg::cur_t        phase_current [wear_pkg::PH_N],
  input  wire logic [CNT_W-1:0]      op_limit,
  input  wire logic [SUM_W-1:0]      sum_limit,
  input  wire logic [SUM_W-1:0]      hourly_limit,
  input  wire logic [TIM_W-1:0]      open_time_limit,
  input  wire logic [TIM_W-1:0]      close_time_limit,
  input  wire logic [PT_W-1:0]       curve_points,
  input  wire wear_pkg::cur_t        curve_current [wear_pkg::N_POINTS],
  input  wire wear_pkg::ops_t        curve_ops [wear_pkg::N_POINTS],
  output logic [CNT_W-1:0]           switching_operation_count,
  output logic [SUM_W-1:0]           phase_a_interrupted_current_sum,
  output logic [SUM_W-1:0]           phase_b_interrupted_current_sum,
  output logic [SUM_W-1:0]           phase_c_interrupted_current_sum,
  output logic [SUM_W-1:0]           hourly_current_sum,
  output logic [CAP_W-1:0]           open_capacity_percent,
  output logic                       maintenance_required,
  output logic                       op_limit_alarm,
  output logic                       current_sum_alarm,
  output logic [PH_N-1:0]            phase_sum_alarm,
  output logic                       hourly_current_sum_alarm,
  output logic                       slow_switchgear_alarm,
  output logic                       wear_busy
);

  logic [31:0]      ms_div_ff;
  logic             ms_tick_ff;
  logic [31:0]      hour_cnt_ff;
  logic             hour_tick;
  logic [1:0]       pos_open_sync_ff;
  logic [1:0]       pos_closed_sync_ff;
  logic [CNT_W-1:0] count_ff;
  logic [SUM_W-1:0] sum_ff [PH_N];
  logic [SUM_W-1:0] hourly_ff;
  cur_t             imax;
  logic             op_alarm_ff;
  logic [PH_N-1:0]  ph_alarm_ff;
  logic             hour_alarm_ff;
  travel_state_e    tstate_ff;
  logic [TIM_W-1:0] tmove_ff;
  logic             slow_ff;
  wear_state_e      wstate_ff;
  cur_t             icap_ff;
  logic [PT_W-1:0]  seg_ff;
  logic [CAP_W-1:0] cap_ff;
  logic [CAP_W-1:0] inc_ff;
  logic             div_start_ff;
  logic [DIV_W-1:0] div_num_ff;
  logic [OPS_W-1:0] div_den_ff;
  logic             div_done;
  logic [DIV_W-1:0] div_quo;
  logic [PT_W-1:0]  last_idx;
  logic [N_POINTS-2:0] seg_hit;
  logic [PT_W-1:0]  seg_idx;
  logic             below_first;
  logic             above_last;
  ops_t             eff_ops [N_POINTS];
  ops_t             nxt_allowed;

  // Millisecond enable and hourly window; both are parameters so simulation can shorten them.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ms_div_ff   <= 32'h0000_0000;
      ms_tick_ff  <= 1'b0;
      hour_cnt_ff <= 32'h0000_0000;
    end else begin
      ms_tick_ff <= (ms_div_ff == MS_CYCLES - 1);
      ms_div_ff  <= (ms_div_ff == MS_CYCLES - 1) ? 32'h0000_0000 : ms_div_ff + 32'h0000_0001;
      if (ms_tick_ff) begin
        hour_cnt_ff <= hour_tick ? 32'h0000_0000 : hour_cnt_ff + 32'h0000_0001;
      end
    end
  end
  assign hour_tick = ms_tick_ff && (hour_cnt_ff == HOUR_TICKS - 1);

  // Position contacts are asynchronous pins, so they pass two flops first.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pos_open_sync_ff   <= 2'h0;
      pos_closed_sync_ff <= 2'h0;
    end else begin
      pos_open_sync_ff   <= {pos_open_sync_ff[0], pos_open_pin};
      pos_closed_sync_ff <= {pos_closed_sync_ff[0], pos_closed_pin};
    end
  end

  // Largest phase current sets the wear of an opening.
  always_comb begin
    imax = phase_current[0];
    for (int p = 1; p < PH_N; p++) begin
      if (phase_current[p] > imax) imax = phase_current[p];
    end
  end

  // Operation counter; a clear and a new operation in one cycle leave a count of one.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= CNT_RST;
    end else if (stat_clear) begin
      count_ff <= (open_cmd || close_cmd) ? CNT_RST + 32'h0000_0001 : CNT_RST;
    end else if (open_cmd || close_cmd) begin
      count_ff <= count_ff + 32'h0000_0001;
    end
  end

  // Per-phase interrupted current sums, one flop array entry per phase.
  for (genvar p = 0; p < PH_N; p++) begin : g_phase
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        sum_ff[p] <= SUM_RST;
      end else if (open_cmd) begin
        sum_ff[p] <= (stat_clear ? SUM_RST : sum_ff[p]) + {16'h0000, phase_current[p]};
      end else if (stat_clear) begin
        sum_ff[p] <= SUM_RST;
      end
    end
  end

  // Hourly sum restarts at each window boundary; an opening in that cycle opens the new window.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hourly_ff <= SUM_RST;
    end else if (open_cmd) begin
      hourly_ff <= ((hour_tick || stat_clear) ? SUM_RST : hourly_ff) + {16'h0000, imax};
    end else if (hour_tick || stat_clear) begin
      hourly_ff <= SUM_RST;
    end
  end

  // Alarms are registered comparisons, one cycle behind the values they watch.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      op_alarm_ff   <= 1'b0;
      ph_alarm_ff   <= '0;
      hour_alarm_ff <= 1'b0;
    end else begin
      op_alarm_ff   <= count_ff > op_limit;
      for (int p = 0; p < PH_N; p++) begin
        ph_alarm_ff[p] <= sum_ff[p] > sum_limit;
      end
      hour_alarm_ff <= hourly_ff > hourly_limit;
    end
  end

  // Travel timer: counts milliseconds from a command until the matching contact closes.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tstate_ff <= T_IDLE;
      tmove_ff  <= '0;
      slow_ff   <= 1'b0;
    end else begin
      case (tstate_ff)
        T_IDLE: begin
          tmove_ff <= '0;
          if (open_cmd) tstate_ff <= T_OPEN;
          else if (close_cmd) tstate_ff <= T_CLOSE;
        end
        T_OPEN: begin
          if (pos_open_sync_ff[1]) tstate_ff <= T_IDLE;
          else if (ms_tick_ff && tmove_ff != TIM_MAX) tmove_ff <= tmove_ff + 16'h0001;
        end
        T_CLOSE: begin
          if (pos_closed_sync_ff[1]) tstate_ff <= T_IDLE;
          else if (ms_tick_ff && tmove_ff != TIM_MAX) tmove_ff <= tmove_ff + 16'h0001;
        end
        default: tstate_ff <= T_IDLE;
      endcase
      // A late move raises the alarm while still moving; a set beats a clear.
      if ((tstate_ff == T_OPEN && tmove_ff > open_time_limit) ||
          (tstate_ff == T_CLOSE && tmove_ff > close_time_limit)) begin
        slow_ff <= 1'b1;
      end else if (stat_clear) begin
        slow_ff <= 1'b0;
      end
    end
  end

  // Effective curve: the last point in use allows no operations at all.
  assign last_idx = (curve_points == 4'h0) ? 4'h0 :
                    (curve_points > 4'hA) ? 4'h9 : curve_points - 4'h1;
  for (genvar k = 0; k < N_POINTS; k++) begin : g_pt
    assign eff_ops[k] = (k >= last_idx) ? 16'h0000 : curve_ops[k];
  end
  for (genvar k = 0; k < N_POINTS - 1; k++) begin : g_seg
    assign seg_hit[k] = (k < last_idx) && (icap_ff > curve_current[k]) && (icap_ff <= curve_current[k+1]);
  end

  // Pick the segment that holds the captured current.
  always_comb begin
    seg_idx = '0;
    for (int k = N_POINTS - 2; k >= 0; k--) begin
      if (seg_hit[k]) seg_idx = k[PT_W-1:0];
    end
  end
  assign below_first = icap_ff <= curve_current[0];
  assign above_last  = icap_ff > curve_current[last_idx];
  assign nxt_allowed = eff_ops[seg_ff] - div_quo[OPS_W-1:0];

  // Wear update: locate the segment, interpolate, then add 100 percent over allowed.
  // Openings that arrive while busy are counted and summed but do not age the capacity.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wstate_ff    <= W_IDLE;
      icap_ff      <= '0;
      seg_ff       <= '0;
      inc_ff       <= '0;
      cap_ff       <= CAP_RST;
      div_start_ff <= 1'b0;
      div_num_ff   <= '0;
      div_den_ff   <= '0;
    end else begin
      div_start_ff <= 1'b0;
      case (wstate_ff)
        W_IDLE: begin
          if (open_cmd) begin
            icap_ff   <= imax;
            wstate_ff <= W_FIND;
          end
        end
        W_FIND: begin
          if (above_last) begin
            inc_ff    <= CAP_FULL;
            wstate_ff <= W_APPL;
          end else if (below_first) begin
            seg_ff       <= '0;
            div_num_ff   <= '0;
            div_den_ff   <= 16'h0001;
            div_start_ff <= 1'b1;
            wstate_ff    <= W_INTP;
          end else begin
            seg_ff       <= seg_idx;
            div_num_ff   <= {16'h0000, eff_ops[seg_idx] - eff_ops[seg_idx + 4'h1]} *
                            {16'h0000, icap_ff - curve_current[seg_idx]};
            div_den_ff   <= curve_current[seg_idx + 4'h1] - curve_current[seg_idx];
            div_start_ff <= 1'b1;
            wstate_ff    <= W_INTP;
          end
        end
        W_INTP: begin
          if (div_done) begin
            if (nxt_allowed == 16'h0000) begin
              inc_ff    <= CAP_FULL;
              wstate_ff <= W_APPL;
            end else begin
              div_num_ff   <= {16'h0000, CAP_FULL};
              div_den_ff   <= nxt_allowed;
              div_start_ff <= 1'b1;
              wstate_ff    <= W_PCT;
            end
          end
        end
        W_PCT: begin
          if (div_done) begin
            inc_ff    <= (div_quo > {16'h0000, CAP_FULL}) ? CAP_FULL : div_quo[CAP_W-1:0];
            wstate_ff <= W_APPL;
          end
        end
        W_APPL: begin
          wstate_ff <= W_IDLE;
        end
        default: wstate_ff <= W_IDLE;
      endcase
      // Capacity saturates at full scale; an update in the clear cycle starts afresh.
      if (wstate_ff == W_APPL) begin
        cap_ff <= ({1'b0, stat_clear ? CAP_RST : cap_ff} + {1'b0, inc_ff} >= {1'b0, CAP_FULL}) ?
                  CAP_FULL : (stat_clear ? CAP_RST : cap_ff) + inc_ff;
      end else if (stat_clear) begin
        cap_ff <= CAP_RST;
      end
    end
  end

  seq_divider u_div (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .start    (div_start_ff),
    .dividend (div_num_ff),
    .divisor  (div_den_ff),
    .busy     (),
    .done     (div_done),
    .quotient (div_quo)
  );

  assign switching_operation_count       = count_ff;
  assign phase_a_interrupted_current_sum = sum_ff[0];
  assign phase_b_interrupted_current_sum = sum_ff[1];
  assign phase_c_interrupted_current_sum = sum_ff[2];
  assign hourly_current_sum              = hourly_ff;
  assign open_capacity_percent           = cap_ff;
  assign maintenance_required            = cap_ff == CAP_FULL;
  assign op_limit_alarm                  = op_alarm_ff;
  assign phase_sum_alarm                 = ph_alarm_ff;
  assign current_sum_alarm               = |ph_alarm_ff;
  assign hourly_current_sum_alarm        = hour_alarm_ff;
  assign slow_switchgear_alarm           = slow_ff;
  assign wear_busy                       = wstate_ff != W_IDLE;

  // Checks that tie the count, the phase a sum, the capacity and the alarms to their causes.
  op_count_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (open_cmd && !stat_clear) |=> count_ff == $past(count_ff) + 32'h0000_0001)
    else $error("operation count did not step");
  op_alarm_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (count_ff > op_limit) && $stable(op_limit) |=> op_limit_alarm)
    else $error("operation alarm missing");
  phase_sum_add_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (open_cmd && !stat_clear) |=> sum_ff[0] == $past(sum_ff[0]) + {16'h0000, $past(phase_current[0])})
    else $error("phase sum not accumulated");
  sum_alarm_pair_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sum_ff[1] > sum_limit) |=> phase_sum_alarm[1] && current_sum_alarm)
    else $error("sum alarms not raised together");
  cap_bound_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cap_ff <= CAP_FULL) && (maintenance_required == (cap_ff == CAP_FULL)))
    else $error("capacity beyond full scale");
  hourly_alarm_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (hourly_ff > hourly_limit) && $stable(hourly_limit) |=> hourly_current_sum_alarm)
    else $error("hourly alarm missing");
  slow_travel_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (tstate_ff == T_OPEN && tmove_ff > open_time_limit) |=> slow_switchgear_alarm [*2])
    else $error("slow alarm not held");
  above_last_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wstate_ff == W_FIND && above_last) |=> wstate_ff == W_APPL && inc_ff == CAP_FULL)
    else $error("current above curve not treated as zero allowed");
  wear_latency_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wstate_ff == W_IDLE && open_cmd) |-> ##[2:72] wstate_ff == W_APPL)
    else $error("wear update took too long");

endmodule : switchgear_wear_monitor

// ### verilog/wear_pkg.sv
// Constants shared by the switchgear wear monitor and its divider.
// Assumes a single 250 MHz system clock; currents arrive as unsigned numbers
// in units of 10 A (0.01 kA), both for measurements and wear curve points.
package wear_pkg;

  localparam int unsigned CLK_HZ   = 250_000_000;   // System clock rate.
  localparam int unsigned MS_HZ    = 1_000;         // Millisecond tick rate.
  localparam int unsigned MS_CYC   = CLK_HZ / MS_HZ; // Cycles per millisecond.
  localparam int unsigned HOUR_S   = 3600;          // Hourly window length in seconds.
  localparam int unsigned HOUR_MS  = HOUR_S * MS_HZ; // Hourly window in millisecond ticks.

  localparam int unsigned N_POINTS = 10;            // Wear curve points, at most.
  localparam int unsigned PT_W     = 4;             // Width of a point index or count.
  localparam int unsigned CUR_W    = 16;            // Current width.
  localparam int unsigned OPS_W    = 16;            // Allowed operations width.
  localparam int unsigned CNT_W    = 32;            // Operation counter width.
  localparam int unsigned SUM_W    = 32;            // Current sum width.
  localparam int unsigned CAP_W    = 16;            // Open capacity width, hundredths of percent.
  localparam int unsigned TIM_W    = 16;            // Travel time width in milliseconds.
  localparam int unsigned DIV_W    = 32;            // Divider dividend and quotient width.
  localparam int unsigned PH_N     = 3;             // Number of phases.

  localparam logic [CAP_W-1:0] CAP_FULL  = 16'h2710; // 100.00 percent.
  localparam logic [CAP_W-1:0] CAP_RST   = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RST   = 32'h0000_0000;
  localparam logic [SUM_W-1:0] SUM_RST   = 32'h0000_0000;
  localparam logic [TIM_W-1:0] TIM_MAX   = 16'hFFFF;

  typedef logic [CUR_W-1:0] cur_t;
  typedef logic [OPS_W-1:0] ops_t;

  // Wear update sequence, one-hot.
  typedef enum logic [4:0] {
    W_IDLE = 5'b00001,
    W_FIND = 5'b00010,
    W_INTP = 5'b00100,
    W_PCT  = 5'b01000,
    W_APPL = 5'b10000
  } wear_state_e;

  // Travel timer direction, one-hot.
  typedef enum logic [2:0] {
    T_IDLE  = 3'b001,
    T_OPEN  = 3'b010,
    T_CLOSE = 3'b100
  } travel_state_e;

endpackage : wear_pkg

// ### verilog/seq_divider.sv
// Iterative unsigned divider, one quotient bit per cycle.
// Assumes start is a one-cycle pulse while busy is low; divide by zero gives all ones.
module seq_divider
  import wear_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             start,
  input  wire logic [DIV_W-1:0] dividend,
  input  wire logic [OPS_W-1:0] divisor,
  output logic                  busy,
  output logic                  done,
  output logic [DIV_W-1:0]      quotient
);

  logic [DIV_W-1:0] rem_ff;
  logic [DIV_W-1:0] quo_ff;
  logic [OPS_W-1:0] den_ff;
  logic [5:0]       cnt_ff;
  logic             busy_ff;
  logic             done_ff;
  logic [DIV_W:0]   trial;

  // The remainder never exceeds the divisor, so a shifted trial of one extra bit is enough.
  assign trial = {rem_ff, quo_ff[DIV_W-1]} - {17'h00000, den_ff};

  // Restoring division: shift in a dividend bit, subtract when it fits.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rem_ff  <= '0;
      quo_ff  <= '0;
      den_ff  <= '0;
      cnt_ff  <= 6'h00;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start && !busy_ff) begin
        rem_ff  <= '0;
        quo_ff  <= dividend;
        den_ff  <= divisor;
        cnt_ff  <= 6'h20;
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        if (!trial[DIV_W]) begin
          rem_ff <= trial[DIV_W-1:0];
          quo_ff <= {quo_ff[DIV_W-2:0], 1'b1};
        end else begin
          rem_ff <= {rem_ff[DIV_W-2:0], quo_ff[DIV_W-1]};
          quo_ff <= {quo_ff[DIV_W-2:0], 1'b0};
        end
        cnt_ff <= cnt_ff - 6'h01;
        if (cnt_ff == 6'h01) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
      end
    end
  end

  assign busy     = busy_ff;
  assign done     = done_ff;
  assign quotient = quo_ff;

endmodule : seq_divider

// ### testbench/breaker_model.sv
// Behavioural circuit breaker: two position contacts that follow open and close commands.
// Assumes commands are one-cycle pulses on clk_sys and a travel time given in clock cycles.
module breaker_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       open_cmd,
  input  wire logic       close_cmd,
  input  wire logic [7:0] travel_cycles,
  output logic            pos_open_pin,
  output logic            pos_closed_pin,
  output logic            moving
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] left_ff;
  logic       to_open_ff;

  // Both contacts read low while the poles travel, so a slow move is never masked by a stale level.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pos_open_pin   <= 1'b0;
      pos_closed_pin <= 1'b1;
      moving         <= 1'b0;
      left_ff        <= 8'h00;
      to_open_ff     <= 1'b0;
    end else if (!moving && (open_cmd || close_cmd)) begin
      pos_open_pin   <= 1'b0;
      pos_closed_pin <= 1'b0;
      moving         <= 1'b1;
      left_ff        <= travel_cycles;
      to_open_ff     <= open_cmd;
    end else if (moving && left_ff == 8'h00) begin
      pos_open_pin   <= to_open_ff;
      pos_closed_pin <= !to_open_ff;
      moving         <= 1'b0;
    end else if (moving) begin
      left_ff <= left_ff - 8'h01;
    end
  end
endmodule : breaker_model

// ### testbench/switchgear_wear_monitor_tb_top.sv
// Self-checking bench for the switchgear wear monitor with a behavioural breaker.
// Assumes short millisecond and hour counts through the design parameters.
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module switchgear_wear_monitor_tb_top
  import wear_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic             clk_sys    = 1'b0;
  logic             rst_n      = 1'b0;
  logic             open_cmd   = 1'b0;
  logic             close_cmd  = 1'b0;
  logic             stat_clear = 1'b0;
  logic [7:0]       travel     = 8'h04;
  logic [CNT_W-1:0] op_lim     = 32'h0000_0003;
  logic [SUM_W-1:0] hr_lim     = 32'h0000_00FA;
  logic [PT_W-1:0]  crv_pts    = 4'h3;
  wire logic        pos_open_pin;
  wire logic        pos_closed_pin;
  wire logic        moving;
  cur_t             ph_cur [PH_N];
  cur_t             crv_cur [N_POINTS];
  ops_t             crv_ops [N_POINTS];
  logic [CNT_W-1:0] op_cnt;
  logic [SUM_W-1:0] sum_a, sum_b, sum_c, hr_sum;
  logic [CAP_W-1:0] cap;
  logic             maint, op_alm, sum_alm, hr_alm, slow_alm, busy;
  logic [PH_N-1:0]  ph_alm;
  int               bad_count    = 0;
  int               total_checks = 0;

  // Clock at 250 MHz.
  always #2 clk_sys = ~clk_sys;

  breaker_model u_brk (.clk_sys(clk_sys), .rst_n(rst_n), .open_cmd(open_cmd), .close_cmd(close_cmd),
    .travel_cycles(travel), .pos_open_pin(pos_open_pin), .pos_closed_pin(pos_closed_pin), .moving(moving));

  // A millisecond is four cycles here, so travel limits are reached in tens of cycles.
  switchgear_wear_monitor #(.MS_CYCLES(4), .HOUR_TICKS(1000)) u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .open_cmd(open_cmd), .close_cmd(close_cmd),
    .pos_open_pin(pos_open_pin), .pos_closed_pin(pos_closed_pin), .stat_clear(stat_clear),
    .phase_current(ph_cur), .op_limit(op_lim), .sum_limit(32'h0000_00FA),
    .hourly_limit(hr_lim), .open_time_limit(16'h0002), .close_time_limit(16'h0002),
    .curve_points(crv_pts), .curve_current(crv_cur), .curve_ops(crv_ops),
    .switching_operation_count(op_cnt), .phase_a_interrupted_current_sum(sum_a),
    .phase_b_interrupted_current_sum(sum_b), .phase_c_interrupted_current_sum(sum_c),
    .hourly_current_sum(hr_sum), .open_capacity_percent(cap), .maintenance_required(maint),
    .op_limit_alarm(op_alm), .current_sum_alarm(sum_alm), .phase_sum_alarm(ph_alm),
    .hourly_current_sum_alarm(hr_alm), .slow_switchgear_alarm(slow_alm), .wear_busy(busy));

  task automatic conclude();
    $display("Checks made %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // One command pulse; outputs are read one step after the edge that takes it.
  task automatic command(input logic is_open, input cur_t a, input cur_t b, input cur_t c);
    @(posedge clk_sys);
    #1;
    ph_cur = '{a, b, c};
    open_cmd  = is_open;
    close_cmd = !is_open;
    @(posedge clk_sys);
    #1;
    open_cmd  = 1'b0;
    close_cmd = 1'b0;
  endtask : command

  // Waits for the wear update and the breaker travel, plus the contact sync lag.
  task automatic settle();
    int n;
    n = 0;
    while ((busy !== 1'b0 || moving) && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 400) begin
      bad_count++;
      conclude();
    end
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic clear_stats();
    @(posedge clk_sys);
    #1;
    stat_clear = 1'b1;
    @(posedge clk_sys);
    #1;
    stat_clear = 1'b0;
  endtask : clear_stats

  // Main sequence; the third point carries 500 operations that must read as zero.
  initial begin
    ph_cur  = '{default: 16'h0000};
    crv_cur = '{0: 16'h0064, 1: 16'h00C8, 2: 16'h0190, default: 16'hFFFF};
    crv_ops = '{0: 16'h03E8, 1: 16'h00C8, 2: 16'h01F4, default: 16'h0000};
    repeat (16) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    `CHK("reset count", 32'h0000_0000, op_cnt)
    `CHK("reset capacity", 16'h0000, cap)
    command(1'b1, 16'h0064, 16'h012C, 16'h00C8);
    `CHK("count open", 32'h0000_0001, op_cnt)
    `CHK("sum a", 32'h0000_0064, sum_a)
    `CHK("sum b", 32'h0000_012C, sum_b)
    `CHK("sum c", 32'h0000_00C8, sum_c)
    `CHK("hourly sum", 32'h0000_012C, hr_sum)
    settle();
    `CHK("capacity interpolated", 16'h0064, cap)
    `CHK("phase alarms", 3'b010, ph_alm)
    `CHK("sum alarm", 1'b1, sum_alm)
    `CHK("hourly alarm", 1'b1, hr_alm)
    hr_lim = 32'h0000_0200;
    @(posedge clk_sys);
    #1;
    `CHK("hourly below raised limit", 1'b0, hr_alm)
    `CHK("fast travel", 1'b0, slow_alm)
    command(1'b0, 16'h0000, 16'h0000, 16'h0000);
    settle();
    `CHK("count close", 32'h0000_0002, op_cnt)
    command(1'b1, 16'h0032, 16'h0000, 16'h0000);
    settle();
    `CHK("capacity first point", 16'h006E, cap)
    `CHK("limit not exceeded", 1'b0, op_alm)
    command(1'b0, 16'h0000, 16'h0000, 16'h0000);
    settle();
    `CHK("limit exceeded", 1'b1, op_alm)
    op_lim = 32'h0000_0004;
    @(posedge clk_sys);
    #1;
    `CHK("limit raised", 1'b0, op_alm)
    travel = 8'h28;
    command(1'b1, 16'h0190, 16'h0000, 16'h0000);
    settle();
    `CHK("last point zero", CAP_FULL, cap)
    `CHK("maintenance", 1'b1, maint)
    `CHK("slow open", 1'b1, slow_alm)
    clear_stats();
    `CHK("cleared count", 32'h0000_0000, op_cnt)
    `CHK("cleared capacity", 16'h0000, cap)
    `CHK("cleared slow", 1'b0, slow_alm)
    command(1'b0, 16'h0000, 16'h0000, 16'h0000);
    settle();
    `CHK("slow close", 1'b1, slow_alm)
    clear_stats();
    travel = 8'h04;
    command(1'b1, 16'h0000, 16'h0191, 16'h0000);
    settle();
    `CHK("above last point", CAP_FULL, cap)
    `CHK("sum b after clear", 32'h0000_0191, sum_b)
    // With two points in use the second point allows nothing: 1000 - 500 leaves 500, so 20 is added.
    clear_stats();
    crv_pts = 4'h2;
    command(1'b1, 16'h0096, 16'h0000, 16'h0000);
    settle();
    `CHK("two point curve", 16'h0014, cap)
    conclude();
  end
endmodule : switchgear_wear_monitor_tb_top
